// ===== verilog/tcl_top.sv
// Copy command interpreter, bar graph feed and lamp logic of the operator panel.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tcl_top
#(
   parameter int TABLES = 128,     // Number of tables per class.
   parameter int LAMPS = 16,       // Number of lamps.
   parameter int FLASH_CYCLES = tcl_pkg::FLASH_CYC, // Flash half period in cycles.
   parameter logic SECOND_FAMILY = 1'b0 // Host family that bars the aux zone.
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Avalon-MM slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Panel outputs.
   output logic [LAMPS-1:0] lamp_lit,
   output tcl_pkg::tcl_graph_t graph,
   output logic [15:0] shown_word
);

   // ==========================================================================
   // Declarations.
   // ==========================================================================
   typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} tcl_state_t; // Copy engine states.

   tcl_pkg::tcl_entry_t str_tab [TABLES]; // Character string tables.
   tcl_pkg::tcl_entry_t num_tab [TABLES]; // Numeral tables.
   tcl_state_t state; // Copy engine state.
   logic [31:0] cmd;   // Command word as written by host.
   logic [31:0] last_cmd; // Last command polled.
   logic [7:0] src;    // Source table number.
   logic [2:0] cmd_zone; // Zone of the command area.
   logic zone_bad;     // Command area sits in a barred zone.
   logic [7:0] cp_src; // Latched source.
   logic [7:0] cp_dst; // Latched destination.
   logic cp_num;       // Latched class.
   tcl_pkg::tcl_entry_t cp_data; // Entry in flight.
   logic [15:0] done_cnt; // Copies done.
   logic [15:0] rej_cnt;  // Changed commands not acted on.
   logic mismatch;     // Last copy was a numeral copy with format mismatch.
   logic [15:0] graph_val; // Graph value word.
   logic [15:0] graph_scale; // Graph full scale.
   logic graph_signed; // Graph shows sign.
   logic graph_upd;    // Graph words changed.
   logic [LAMPS-1:0] lamp_bits; // Host lamp bits.
   logic [LAMPS-1:0] lamp_flash; // Flash attribute per lamp.
   logic [31:0] flash_cnt; // Flash timer.
   logic flash_ph;     // Flash phase.
   logic [7:0] tab_idx; // Access index, bit 7 picks numeral class.
   logic [7:0] disp_sel; // Displayed string table.
   logic acc_w;        // Accepted write.
   logic acc_r;        // Accepted read.
   logic [31:0] next_readdata; // Read mux.
   logic cmd_changed;  // Poll sees a difference.
   logic cmd_valid;    // Type and numbers valid.
   logic [3:0] cmd_type; // Copy type field.
   logic [7:0] cmd_dst; // Destination field.

   // Returns high when a table number lies in 000 to 127.
   function automatic logic in_range(input logic [7:0] n);
      return n <= tcl_pkg::TABLE_MAX;
   endfunction

   // ==========================================================================
   // Bus slave: one wait cycle, answer at the second edge.
   // ==========================================================================
   logic ack; // Answer cycle flag.

   // Holds waitrequest high for the first cycle of each request.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= (avs_read || avs_write) && !ack;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign acc_w = avs_write && ack;
   assign acc_r = avs_read && !ack;

   // Stores host-written words.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd <= tcl_pkg::CMD_RESET;
         src <= 8'h00;
         cmd_zone <= tcl_pkg::ZONE_DATA;
         graph_val <= 16'h0000;
         graph_scale <= 16'h0100;
         graph_signed <= 1'b0;
         lamp_bits <= '0;
         lamp_flash <= '0;
         tab_idx <= 8'h00;
         disp_sel <= 8'h00;
      end
      else if (acc_w)
      begin
         unique case (avs_address)
            tcl_pkg::REG_COPY_CMD: cmd <= avs_writedata;
            tcl_pkg::REG_COPY_SRC: src <= avs_writedata[7:0];
            tcl_pkg::REG_CMD_ZONE: cmd_zone <= avs_writedata[2:0];
            tcl_pkg::REG_GRAPH_VAL: graph_val <= avs_writedata[15:0];
            tcl_pkg::REG_GRAPH_CFG:
            begin
               graph_scale <= avs_writedata[15:0];
               graph_signed <= avs_writedata[16];
            end
            tcl_pkg::REG_LAMP_BITS: lamp_bits <= avs_writedata[LAMPS-1:0];
            tcl_pkg::REG_LAMP_ATTR: lamp_flash <= avs_writedata[LAMPS-1:0];
            tcl_pkg::REG_TABLE_IDX: tab_idx <= avs_writedata[7:0];
            tcl_pkg::REG_DISP_SEL: disp_sel <= avs_writedata[7:0];
            default:
            begin
               // Unmapped or read-only: write ignored; table data writes are stored by the table write blocks.
            end
         endcase
      end
   end

   // Selects the read answer, registered in the first request cycle.
   always_comb
   begin
      unique case (avs_address)
         tcl_pkg::REG_COPY_CMD: next_readdata = cmd;
         tcl_pkg::REG_COPY_SRC: next_readdata = {24'h0, src};
         tcl_pkg::REG_COPY_STAT: next_readdata = {done_cnt[14:0], mismatch, rej_cnt[13:0], state};
         tcl_pkg::REG_CMD_ZONE: next_readdata = {28'h0, zone_bad, cmd_zone};
         tcl_pkg::REG_GRAPH_VAL: next_readdata = {16'h0, graph_val};
         tcl_pkg::REG_GRAPH_CFG: next_readdata = {15'h0, graph_signed, graph_scale};
         tcl_pkg::REG_GRAPH_STAT: next_readdata = {23'h0, graph};
         tcl_pkg::REG_LAMP_BITS: next_readdata = 32'(lamp_bits);
         tcl_pkg::REG_LAMP_ATTR: next_readdata = 32'(lamp_flash);
         tcl_pkg::REG_LAMP_STAT: next_readdata = 32'(lamp_lit);
         tcl_pkg::REG_TABLE_IDX: next_readdata = {24'h0, tab_idx};
         tcl_pkg::REG_TABLE_DATA: next_readdata = tab_idx[7] ? 32'(num_tab[tab_idx[6:0]])
                                                             : 32'(str_tab[tab_idx[6:0]]);
         tcl_pkg::REG_DISP_SEL: next_readdata = {24'h0, disp_sel};
         default: next_readdata = tcl_pkg::UNMAPPED;
      endcase
   end

   // Read data register, valid at the edge where waitrequest is low.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (acc_r)
      begin
         avs_readdata <= next_readdata;
      end
   end

   // ==========================================================================
   // Copy command poll.
   // ==========================================================================
   // Barred zones ignore the poll.
   assign zone_bad = (cmd_zone == tcl_pkg::ZONE_DELAY) || (cmd_zone == tcl_pkg::ZONE_TALLY)
                     || (cmd_zone == tcl_pkg::ZONE_AUX && SECOND_FAMILY) || (cmd_zone == 3'h7);

   assign cmd_type = cmd[tcl_pkg::TYPE_LSB +: 4];
   assign cmd_dst = cmd[tcl_pkg::DST_LSB +: 8];
   // Either word changing is a new command.
   assign cmd_changed = ({cmd, 24'h0, src} != {last_cmd, 24'h0, cp_src}) && !zone_bad;
   assign cmd_valid = (cmd_type == tcl_pkg::COPY_STR || cmd_type == tcl_pkg::COPY_NUM)
                      && in_range(src) && in_range(cmd_dst);

   // Copy engine: poll, read entry, write entry.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= S_IDLE;
         last_cmd <= tcl_pkg::CMD_RESET;
         cp_src <= 8'h00;
         cp_dst <= 8'h00;
         cp_num <= 1'b0;
      end
      else
      begin
         unique case (state)
            S_IDLE:
            begin
               // Every poll remembers the seen command so a repeat needs a change.
               if (cmd_changed)
               begin
                  last_cmd <= cmd;
                  cp_src <= src;
                  cp_dst <= cmd_dst;
                  cp_num <= (cmd_type == tcl_pkg::COPY_NUM);
                  if (cmd_valid)
                  begin
                     state <= S_READ;
                  end
               end
            end
            S_READ: state <= S_WRITE;
            S_WRITE: state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // Fetches the source entry.
   always_ff @(posedge mclk)
   begin
      if (state == S_READ)
      begin
         cp_data <= cp_num ? num_tab[cp_src[6:0]] : str_tab[cp_src[6:0]];
      end
   end

   // Numeral table writes.
   always_ff @(posedge mclk)
   begin
      if (state == S_WRITE && cp_num)
      begin
         // Data moves as stored; the destination keeps its own format tags.
         num_tab[cp_dst[6:0]].data <= cp_data.data;
      end
      else if (acc_w && avs_address == tcl_pkg::REG_TABLE_DATA && tab_idx[7])
      begin
         num_tab[tab_idx[6:0]] <= avs_writedata[19:0];
      end
   end

   // String table writes.
   always_ff @(posedge mclk)
   begin
      if (state == S_WRITE && !cp_num)
      begin
         str_tab[cp_dst[6:0]] <= cp_data;
      end
      else if (acc_w && avs_address == tcl_pkg::REG_TABLE_DATA && !tab_idx[7])
      begin
         str_tab[tab_idx[6:0]] <= avs_writedata[19:0];
      end
   end

   // Copy statistics and mismatch flag.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         done_cnt <= 16'h0000;
         rej_cnt <= 16'h0000;
         mismatch <= 1'b0;
      end
      else
      begin
         if (state == S_WRITE)
         begin
            done_cnt <= done_cnt + 16'h0001;
            mismatch <= cp_num && (cp_data.method != num_tab[cp_dst[6:0]].method
                                   || cp_data.words != num_tab[cp_dst[6:0]].words);
         end
         if (state == S_IDLE && cmd_changed && !cmd_valid)
         begin
            rej_cnt <= rej_cnt + 16'h0001;
         end
      end
   end

   // Only the displayed table is read out to the screen.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         shown_word <= 16'h0000;
      end
      else
      begin
         shown_word <= str_tab[disp_sel[6:0]].data;
      end
   end

   // ==========================================================================
   // Bar graph.
   // ==========================================================================
   // Fires the graph once the new words are stored.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         graph_upd <= 1'b0;
      end
      else
      begin
         graph_upd <= acc_w && (avs_address == tcl_pkg::REG_GRAPH_VAL
                                || avs_address == tcl_pkg::REG_GRAPH_CFG);
      end
   end

   tcl_graph u_graph
   (
      .mclk(mclk),
      .rstn(rstn),
      .value(graph_val),
      .signed_show(graph_signed),
      .full_scale(graph_scale),
      .update(graph_upd),
      .result(graph)
   );

   // ==========================================================================
   // Lamps.
   // ==========================================================================
   // Flash timer toggles the phase each half period.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         flash_cnt <= 32'h0000_0000;
         flash_ph <= 1'b0;
      end
      else if (flash_cnt >= 32'(FLASH_CYCLES - 1))
      begin
         flash_cnt <= 32'h0000_0000;
         flash_ph <= !flash_ph;
      end
      else
      begin
         flash_cnt <= flash_cnt + 32'h0000_0001;
      end
   end

   // Each lamp follows its own bit: off unlit, on lit or flashing.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         lamp_lit <= '0;
      end
      else
      begin
         lamp_lit <= lamp_bits & (~lamp_flash | {LAMPS{flash_ph}});
      end
   end

endmodule

// ===== verilog/tcl_pkg.sv
// Package of constants, types and register map for the table copy and lamp word block.
package tcl_pkg;

   // ==========================================================================
   // Register map (word offsets are byte addresses).
   // ==========================================================================
   localparam logic [7:0] REG_COPY_CMD = 8'h00;   // Copy command word, written by host.
   localparam logic [7:0] REG_COPY_SRC = 8'h04;   // Copy source table number.
   localparam logic [7:0] REG_COPY_STAT = 8'h08;  // Copy status and counters.
   localparam logic [7:0] REG_CMD_ZONE = 8'h0C;   // Zone holding the command area.
   localparam logic [7:0] REG_GRAPH_VAL = 8'h10;  // Value feeding the bar graph.
   localparam logic [7:0] REG_GRAPH_CFG = 8'h14;  // Bar graph configuration.
   localparam logic [7:0] REG_GRAPH_STAT = 8'h18; // Bar graph result.
   localparam logic [7:0] REG_LAMP_BITS = 8'h1C;  // Lamp control bits.
   localparam logic [7:0] REG_LAMP_ATTR = 8'h20;  // Lamp flash attributes.
   localparam logic [7:0] REG_LAMP_STAT = 8'h24;  // Lamp display state.
   localparam logic [7:0] REG_TABLE_IDX = 8'h28;  // Table access index.
   localparam logic [7:0] REG_TABLE_DATA = 8'h2C; // Table access data.
   localparam logic [7:0] REG_DISP_SEL = 8'h30;   // Table shown on screen.

   // ==========================================================================
   // Field layout of the copy command word.
   // ==========================================================================
   localparam int DST_LSB = 0;       // Destination table number, bits 7:0.
   localparam int TYPE_LSB = 8;      // Copy type, bits 11:8.
   localparam logic [3:0] COPY_STR = 4'h0;  // Copy between string tables.
   localparam logic [3:0] COPY_NUM = 4'h1;  // Copy between numeral tables.
   localparam logic [7:0] TABLE_MAX = 8'h7F; // Highest table number, 127.
   localparam logic [31:0] CMD_RESET = 32'h0000_0F00; // Invalid type at reset.

   // ==========================================================================
   // Zone codes of host memory.
   // ==========================================================================
   localparam logic [2:0] ZONE_DATA = 3'h0;  // data_memory_zone.
   localparam logic [2:0] ZONE_INT = 3'h1;   // internal_relay_zone.
   localparam logic [2:0] ZONE_DELAY = 3'h2; // delay_element_zone.
   localparam logic [2:0] ZONE_TALLY = 3'h3; // event_tally_zone.
   localparam logic [2:0] ZONE_HOLD = 3'h4;  // holding_relay_zone.
   localparam logic [2:0] ZONE_AUX = 3'h5;   // aux_relay_zone.
   localparam logic [2:0] ZONE_LINK = 3'h6;  // link_relay_zone.

   // ==========================================================================
   // Timing and misc.
   // ==========================================================================
   localparam int CLK_MHZ = 200;          // Clock rate in MHz.
   localparam int FLASH_MS = 250;         // Half period of lamp flashing, ms.
   localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ; // Cycles per half period.
   localparam logic [31:0] UNMAPPED = 32'hDEAD_0000;    // Read value at no register.

   // Table entry with its format tags.
   typedef struct packed {
      logic [15:0] data;  // Stored word.
      logic [1:0] method; // Display method.
      logic [1:0] words;  // Registered word count minus one.
   } tcl_entry_t;

   // Bar graph result.
   typedef struct packed {
      logic shown;        // Graph is drawn.
      logic stars;        // Percentage text shown as asterisks.
      logic [6:0] pct;    // Percentage, 0 to 100.
   } tcl_graph_t;

endpackage

// ===== verilog/tcl_graph.sv
// Bar graph value checker that turns a decimal digit word into a percentage.
`timescale 1ns/1ps
module tcl_graph
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Value and configuration.
   input wire logic [15:0] value,
   input wire logic signed_show,
   input wire logic [15:0] full_scale,
   input wire logic update,
   // Result.
   output tcl_pkg::tcl_graph_t result
);

   // Returns high when every nibble is a decimal digit.
   function automatic logic is_decimal(input logic [15:0] w);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         if (w[i*4 +: 4] > 4'h9)
         begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // Converts a digit word to binary.
   function automatic logic [13:0] to_bin(input logic [15:0] w);
      return 14'(w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0]);
   endfunction

   logic negative; // Top digit F on an unsigned graph.
   logic [13:0] mag; // Value in binary.
   logic [13:0] scale; // Full scale in binary.
   logic [20:0] prod; // Value times one hundred.

   // Classifies the value and forms the percentage.
   always_comb
   begin
      negative = !signed_show && (value[15:12] == 4'hF);
      mag = to_bin(value);
      scale = to_bin(full_scale);
      prod = 21'(mag) * 21'd100;
   end

   // Updates the result whenever new words arrive.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         result <= '0;
      end
      else if (update)
      begin
         if (negative)
         begin
            result.shown <= 1'b1;
            result.stars <= 1'b1;
            result.pct <= 7'h00;
         end
         else if (!is_decimal(value) || !is_decimal(full_scale) || scale == 14'h0)
         begin
            result <= '0;
         end
         else
         begin
            result.shown <= 1'b1;
            result.stars <= 1'b0;
            result.pct <= (mag >= scale) ? 7'd100 : 7'(prod / 21'(scale));
         end
      end
   end

endmodule

// ===== test/tcl_host.sv
// Host controller model that reads and writes panel words over the bus.
`timescale 1ns/1ps
module tcl_host
(
   // Clock.
   input wire logic mclk,
   // Bus master side.
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   int hang = 0; // Requests that never saw an answer.
   // Idle bus at time zero.
   initial
   begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
   end
   // One transfer, held until waitrequest is low.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 100);
      if (avs_waitrequest !== 1'b0)
         hang++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Released data show the inverse.
      avs_writedata <= ~d;
   endtask
endmodule

// ===== test/tcl_chk.sv
// Checker of bus handshake, graph and lamp behaviour at the top ports.
`timescale 1ns/1ps
module tcl_chk
#(
   parameter int LAMPS = 16 // Number of lamps.
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Bus.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Panel outputs.
   input wire logic [LAMPS-1:0] lamp_lit,
   input wire tcl_pkg::tcl_graph_t graph,
   input wire logic [15:0] shown_word
);
   logic acc; // A write is taken at this edge.
   logic gv; // Taken write to the graph value.
   logic [LAMPS-1:0] bits; // Shadow of lamp control bits.
   logic [LAMPS-1:0] attr; // Shadow of flash attributes.
   logic sgn; // Shadow of graph sign display.
   assign acc = avs_write && !avs_waitrequest;
   assign gv = acc && avs_address == tcl_pkg::REG_GRAPH_VAL;
   // ==========================================================================
   // Shadows follow taken writes.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         bits <= '0;
         attr <= '0;
         sgn <= 1'b0;
      end
      else if (acc)
      begin
         if (avs_address == tcl_pkg::REG_LAMP_BITS)
            bits <= avs_writedata[LAMPS-1:0];
         if (avs_address == tcl_pkg::REG_LAMP_ATTR)
            attr <= avs_writedata[LAMPS-1:0];
         if (avs_address == tcl_pkg::REG_GRAPH_CFG)
            sgn <= avs_writedata[16];
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ==========================================================================
   // Assertions.
   chk_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
      else $error("first request cycle not stalled");
   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");
   chk_idle_ready: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
   chk_unmapped_rd: assert property (avs_read && !avs_waitrequest && avs_address > tcl_pkg::REG_DISP_SEL
      |-> avs_readdata == tcl_pkg::UNMAPPED)
      else $error("unmapped read value wrong");
   chk_lamp_off: assert property ((lamp_lit & ~$past(bits)) == '0)
      else $error("lamp lit with control bit low");
   chk_lamp_follow: assert property (($past(bits) & ~$past(attr)) == (lamp_lit & ~$past(attr)))
      else $error("steady lamp does not follow bit");
   chk_graph_neg: assert property (gv && avs_writedata[15:12] == 4'hF && !sgn
      |-> ##2 graph.stars && graph.pct == 7'h00)
      else $error("negative value not shown as zero with stars");
   chk_graph_hex: assert property (gv && (avs_writedata[11:8] > 4'h9 || avs_writedata[7:4] > 4'h9 ||
      avs_writedata[3:0] > 4'h9) |-> ##2 !graph.shown)
      else $error("hexadecimal value drawn");
   chk_pct_cap: assert property (graph.pct <= 7'h64)
      else $error("percentage above full scale");
endmodule
bind tcl_top tcl_chk #(.LAMPS(LAMPS)) u_chk (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .lamp_lit(lamp_lit), .graph(graph), .shown_word(shown_word));

// ===== test/tcl_top_tb_top.sv
// Self-checking bench for the copy interpreter, bar graph and lamps.
`timescale 1ns/1ps
module tcl_top_tb_top;
   logic mclk = 1'b0; // System clock.
   logic rstn = 1'b0; // Reset, active low.
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] lamp_lit;
   tcl_pkg::tcl_graph_t graph;
   logic [15:0] shown_word;
   int err_total = 0; // Mismatches.
   int total_checks = 0; // Comparisons.
   int seed = 32'h6a15; // Random seed.
   int v; // Scratch value.
   logic [15:0] tab [512]; // Model tables: strings 0-127, numerals 256 up.
   logic [31:0] last_cmd = tcl_pkg::CMD_RESET; // Model copy command.
   logic [31:0] last_src = 32'h0; // Model copy source.
   logic [31:0] q; // Read data.
   logic [1:0] fl; // Flash phases seen.
   always #2.5 mclk = ~mclk;
   tcl_top #(.FLASH_CYCLES(4)) u_tcl_top (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .lamp_lit(lamp_lit), .graph(graph), .shown_word(shown_word));
   tcl_host u_host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // Compare and count.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Verdict and end of run.
   task automatic results();
      if (err_total == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Bus write; the model copies on a change.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] nc;
      logic [31:0] ns;
      u_host.xfer(1'b1, a, d, q);
      err_total += u_host.hang;
      if (u_host.hang > 0)
         results();
      nc = (a == tcl_pkg::REG_COPY_CMD) ? d : last_cmd;
      ns = (a == tcl_pkg::REG_COPY_SRC) ? d : last_src;
      if ({nc, ns} != {last_cmd, last_src} && nc[11:8] <= 4'h1 && nc[7:0] <= 8'h7F && ns[7:0] <= 8'h7F)
         tab[{nc[8], nc[7:0]}] = tab[{nc[8], ns[7:0]}];
      last_cmd = nc;
      last_src = ns;
   endtask
   // Bus read.
   task automatic rd(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, q);
      err_total += u_host.hang;
      if (u_host.hang > 0)
         results();
   endtask
   // Host copy: destination and type first, then source.
   task automatic copy(input logic [3:0] t, input logic [7:0] dst, input logic [7:0] src);
      wr(tcl_pkg::REG_COPY_CMD, {20'h0, t, dst});
      wr(tcl_pkg::REG_COPY_SRC, {24'h0, src});
   endtask
   // Fill a table entry with a random word.
   task automatic tput(input logic c, input logic [6:0] n);
      v = $random(seed);
      wr(tcl_pkg::REG_TABLE_IDX, {24'h0, c, n});
      wr(tcl_pkg::REG_TABLE_DATA, {12'h0, v[15:0], 4'h0});
      tab[{c, 1'b0, n}] = v[15:0];
   endtask
   // Let a copy land, then compare.
   task automatic tchk(input logic c, input logic [6:0] n);
      repeat (6) @(posedge mclk);
      check("shown_word", shown_word, tab[4]);
      wr(tcl_pkg::REG_TABLE_IDX, {24'h0, c, n});
      rd(tcl_pkg::REG_TABLE_DATA);
      check("table", q[19:4], tab[{c, 1'b0, n}]);
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      rd(tcl_pkg::REG_COPY_CMD);
      check("copy_cmd", q, tcl_pkg::CMD_RESET);
      rd(8'h40);
      check("unmapped", q, tcl_pkg::UNMAPPED);
      for (int z = 0; z < 7; z++)
      begin
         wr(tcl_pkg::REG_CMD_ZONE, z);
         rd(tcl_pkg::REG_CMD_ZONE);
         check("zone", q[3:0], {z == 2 || z == 3, 3'(z)});
      end
      // String and numeral tables, one on screen.
      foreach (tab[i])
         tab[i] = 16'h0;
      tput(1'b0, 7'd10);
      tput(1'b0, 7'd11);
      tput(1'b0, 7'd127);
      tput(1'b1, 7'd3);
      wr(tcl_pkg::REG_DISP_SEL, 32'h4);
      copy(4'h0, 8'h04, 8'h0A);
      tchk(1'b0, 7'd4);
      tput(1'b0, 7'd10);
      wr(tcl_pkg::REG_COPY_CMD, 32'h0000_0004);
      tchk(1'b0, 7'd4);
      wr(tcl_pkg::REG_COPY_CMD, 32'h0000_0F04);
      wr(tcl_pkg::REG_COPY_CMD, 32'h0000_0004);
      tchk(1'b0, 7'd4);
      for (int t = 2; t < 16; t++)
      begin
         copy(4'(t), 8'h04, 8'(10 + t % 2));
         tchk(1'b0, 7'd4);
      end
      wr(tcl_pkg::REG_COPY_SRC, 32'h80);
      wr(tcl_pkg::REG_COPY_CMD, 32'h0000_0004);
      tchk(1'b0, 7'd4);
      wr(tcl_pkg::REG_COPY_SRC, 32'h7F);
      tchk(1'b0, 7'd4);
      copy(4'h1, 8'h05, 8'h03);
      tchk(1'b1, 7'd5);
      // Bar graph with a full scale of 100.
      wr(tcl_pkg::REG_GRAPH_CFG, 32'h0000_0100);
      repeat (6)
      begin
         v = {$random(seed)} % 200;
         wr(tcl_pkg::REG_GRAPH_VAL, {20'h0, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)});
         repeat (2) @(posedge mclk);
         check("graph", graph, {2'b10, 7'(v > 100 ? 100 : v)});
      end
      wr(tcl_pkg::REG_GRAPH_VAL, 32'h0000_F012);
      repeat (2) @(posedge mclk);
      check("graph_neg", {graph.stars, graph.pct}, 8'h80);
      wr(tcl_pkg::REG_GRAPH_VAL, 32'h0000_01A0);
      repeat (2) @(posedge mclk);
      check("graph_hex", graph.shown, 1'b0);
      // Steady lamps, then flashing ones.
      wr(tcl_pkg::REG_LAMP_ATTR, 32'h0);
      repeat (4)
      begin
         v = $random(seed);
         wr(tcl_pkg::REG_LAMP_BITS, v);
         repeat (2) @(posedge mclk);
         check("lamp", lamp_lit, v[15:0]);
      end
      wr(tcl_pkg::REG_LAMP_ATTR, 32'hFFFF);
      wr(tcl_pkg::REG_LAMP_BITS, 32'h00FF);
      fl = 2'b00;
      repeat (20)
      begin
         @(posedge mclk);
         fl = fl | {lamp_lit === 16'h00FF, lamp_lit === 16'h0000};
      end
      check("flash", fl, 2'b11);
      results();
   end
endmodule
